/* File: verilog/uart_rx_pkg.sv */
// constants, register map and types for the serial receive front end
// assumes one system clock; all users import the whole package
package uart_rx_pkg;

    // ----------------------------------------
    // bus and register map
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int DIV_W = 12;
    localparam logic [1:0] IDX_CTRL = 2'h0;
    localparam logic [1:0] IDX_STATUS = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;
    localparam logic [1:0] IDX_BAUD = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int CTRL_RX_ENABLE = 0;
    localparam int CTRL_DOUBLE_SPEED = 1;
    localparam int CTRL_ADDR_FILTER = 2;
    localparam int CTRL_PARITY_ENABLE = 3;
    localparam int CTRL_SIZE_LO = 4;
    localparam int STAT_RX_COMPLETE = 0;
    localparam int STAT_FRAMING_ERROR = 1;
    localparam int STAT_NINTH_BIT = 2;
    localparam int STAT_BUSY = 3;
    localparam int DATA_NINTH_POS = 8;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [2:0] SIZE_CODE_RESET = 3'h3;
    localparam logic [DIV_W-1:0] BAUD_DIVISOR_RESET = 12'h067;

    // ----------------------------------------
    // sampling figures
    // ----------------------------------------
    localparam logic [4:0] SPB_NORMAL = 5'h10;
    localparam logic [4:0] SPB_DOUBLE = 5'h08;
    localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
    localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
    localparam logic [4:0] DS_STOP_RELEASE = 5'h07;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;
    localparam logic [3:0] MAX_DATA_BITS = 4'h9;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;

endpackage : uart_rx_pkg

/* File: verilog/sample_tick_if.sv */
// carries divisor, restart and sample tick between receiver and tick generator
// assumes both ends share the system clock
`timescale 1ns/1ps
interface sample_tick_if #(parameter int DIV_W = 12);
    logic [DIV_W-1:0] divisor;
    logic restart;
    logic tick;
    modport gen (input divisor, input restart, output tick);
    modport user (output divisor, output restart, input tick);
endinterface : sample_tick_if

/* File: verilog/sample_tick_gen.sv */
// sample-rate tick generator: one tick every divisor+1 clocks
// assumes restart is a single-cycle request from the receiver
`timescale 1ns/1ps
module sample_tick_gen #(
    parameter int DIV_W = 12
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    sample_tick_if.gen tk
);
    logic [DIV_W-1:0] cnt_q;
    logic tick_q;

    // ----------------------------------------
    // divider
    // ----------------------------------------
    // restart realigns the sample grid to the start edge
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else if (tk.restart) begin
            cnt_q <= tk.divisor;
            tick_q <= 1'b0;
        end else if (cnt_q == '0) begin
            cnt_q <= tk.divisor;
            tick_q <= 1'b1;
        end else begin
            cnt_q <= cnt_q - 1'b1;
            tick_q <= 1'b0;
        end
    end

    assign tk.tick = tick_q;

    a_tick_after_restart: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        tk.restart |=> !tk.tick) else $error("tick right after restart");
endmodule : sample_tick_gen

/* File: verilog/rx_line_sync.sv */
// two-stage synchroniser for the serial receive line
// assumes the line idles high; both stages reset to idle
`timescale 1ns/1ps
module rx_line_sync (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic line_i,
    output logic line_o
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else begin
            meta_q <= line_i;
            sync_q <= meta_q;
        end
    end

    assign line_o = sync_q;

    a_sync_two_stage: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
        ##2 line_o == $past(line_i, 2)) else $error("sync latency not two clocks");
endmodule : rx_line_sync

/* File: verilog/uart_rx_recovery_addr_filter.sv */
// serial receive front end: start detection, bit recovery, address filter
// assumes AXI4-Lite master on SYS_CLK; serial line asynchronous, idles high
`timescale 1ns/1ps
module uart_rx_recovery_addr_filter #(
    parameter int DIV_W = uart_rx_pkg::DIV_W
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic [uart_rx_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [uart_rx_pkg::DATA_W-1:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [uart_rx_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [uart_rx_pkg::DATA_W-1:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic SERIAL_RECEIVE_INPUT
);
    import uart_rx_pkg::*;

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic rx_enable_q;
    logic double_speed_select_q;
    logic address_filter_enable_q;
    logic parity_enable_q;
    logic [2:0] size_code_q;
    logic [DIV_W-1:0] baud_divisor_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_fire;
    logic rd_take;
    logic pop;
    logic line_s;
    logic line_prev_q;
    logic falling;
    rx_state_t state_q;
    logic [4:0] cnt_q;
    logic [4:0] num;
    logic [4:0] spb;
    logic [4:0] vf;
    logic vote_last;
    logic [1:0] v_q;
    logic maj;
    logic [3:0] bit_idx_q;
    logic [3:0] data_bits;
    logic [3:0] frame_bits;
    logic [9:0] frame_q;
    logic [7:0] keep;
    logic commit;
    logic frame_type;
    logic drop;
    logic rx_complete_q;
    logic framing_error_flag_q;
    logic ninth_received_bit_q;
    logic [7:0] rx_data_q;

    sample_tick_if #(.DIV_W(DIV_W)) tk ();

    rx_line_sync u_sync (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .line_i(SERIAL_RECEIVE_INPUT),
        .line_o(line_s)
    );

    sample_tick_gen #(.DIV_W(DIV_W)) u_tick (
        .SYS_CLK(SYS_CLK),
        .RSTN(RSTN),
        .tk(tk)
    );

    // ----------------------------------------
    // sampling arithmetic
    // ----------------------------------------
    assign spb = double_speed_select_q ? SPB_DOUBLE : SPB_NORMAL;
    assign vf = double_speed_select_q ? VOTE_FIRST_DOUBLE : VOTE_FIRST_NORMAL;
    assign num = (cnt_q >= spb) ? 5'h01 : cnt_q + 5'h01;
    assign vote_last = (num == vf + 5'h02);
    // third vote is the live sample, so decision lands on the last voting tick
    assign maj = (v_q[0] & v_q[1]) | (v_q[0] & line_s) | (v_q[1] & line_s);
    assign falling = line_prev_q && !line_s;
    // out-of-range size codes fall back to the widest frame
    assign data_bits = (size_code_q > 3'h4) ? MAX_DATA_BITS
                                           : MIN_DATA_BITS + {1'b0, size_code_q};
    assign frame_bits = data_bits + {3'h0, parity_enable_q};
    assign tk.divisor = baud_divisor_q;
    assign tk.restart = (state_q == RX_IDLE) && rx_enable_q && falling;
    assign commit = (state_q == RX_STOP) && tk.tick && vote_last;
    assign frame_type = (data_bits == MAX_DATA_BITS) ? frame_q[8] : maj;
    // filter is re-evaluated every frame, so data frames keep dropping until cleared
    assign drop = address_filter_enable_q && !frame_type;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_keep
            assign keep[gi] = (4'(gi) < data_bits);
        end
    endgenerate

    // ----------------------------------------
    // edge memory
    // ----------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            line_prev_q <= 1'b1;
        end else begin
            line_prev_q <= line_s;
        end
    end

    // ----------------------------------------
    // recovery state machine
    // ----------------------------------------
    // edge search runs at clock rate so the resync is as fine as possible
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            state_q <= RX_IDLE;
            cnt_q <= 5'h00;
            bit_idx_q <= 4'h0;
        end else if (!rx_enable_q) begin
            state_q <= RX_IDLE;
            cnt_q <= 5'h00;
        end else begin
            case (state_q)
                RX_IDLE: begin
                    if (falling) begin
                        state_q <= RX_START;
                        cnt_q <= 5'h01;
                    end
                end
                RX_START: begin
                    if (tk.tick) begin
                        cnt_q <= num;
                        if (vote_last && maj) begin
                            state_q <= RX_IDLE;
                        end else if (num == spb) begin
                            state_q <= RX_DATA;
                            bit_idx_q <= 4'h0;
                        end
                    end
                end
                RX_DATA: begin
                    if (tk.tick) begin
                        cnt_q <= num;
                        if (num == spb) begin
                            bit_idx_q <= bit_idx_q + 4'h1;
                            if (bit_idx_q == frame_bits - 4'h1) begin
                                state_q <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (tk.tick) begin
                        cnt_q <= num;
                        // later stop bits are never looked at
                        if (vote_last && !double_speed_select_q) begin
                            state_q <= RX_IDLE;
                        end else if (num == DS_STOP_RELEASE && double_speed_select_q) begin
                            state_q <= RX_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= RX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // votes and frame bits
    // ----------------------------------------
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            v_q <= 2'h0;
            frame_q <= 10'h000;
        end else if (tk.tick && state_q != RX_IDLE) begin
            if (num == vf) begin
                v_q[0] <= line_s;
            end
            if (num == vf + 5'h01) begin
                v_q[1] <= line_s;
            end
            if (state_q == RX_DATA && vote_last) begin
                frame_q[bit_idx_q] <= maj;
            end
        end
    end

    // ----------------------------------------
    // holding register
    // ----------------------------------------
    // single-entry hold; a new frame overwrites an unread one
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rx_complete_q <= 1'b0;
            framing_error_flag_q <= 1'b0;
            ninth_received_bit_q <= 1'b0;
            rx_data_q <= 8'h00;
        end else if (!rx_enable_q) begin
            rx_complete_q <= 1'b0;
        end else if (commit && !drop) begin
            rx_complete_q <= 1'b1;
            framing_error_flag_q <= !maj;
            ninth_received_bit_q <= frame_q[8] && (data_bits == MAX_DATA_BITS);
            rx_data_q <= frame_q[7:0] & keep;
        end else if (pop) begin
            rx_complete_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // write channel
    // ----------------------------------------
    assign wr_fire = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY <= 1'b1;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= 4'h0;
        end else begin
            if (S_AXI_AWREADY && S_AXI_AWVALID) begin
                awaddr_q <= S_AXI_AWADDR;
                S_AXI_AWREADY <= 1'b0;
            end
            if (S_AXI_WREADY && S_AXI_WVALID) begin
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
                S_AXI_WREADY <= 1'b0;
            end
            if (wr_fire) begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= (awaddr_q[3:2] == IDX_CTRL || awaddr_q[3:2] == IDX_BAUD)
                               ? RESP_OKAY : RESP_SLVERR;
            end
            if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
                S_AXI_AWREADY <= 1'b1;
                S_AXI_WREADY <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // no transmit path lives here; the filter bit only gates reception
    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            rx_enable_q <= 1'b0;
            double_speed_select_q <= 1'b0;
            address_filter_enable_q <= 1'b0;
            parity_enable_q <= 1'b0;
            size_code_q <= SIZE_CODE_RESET;
            baud_divisor_q <= BAUD_DIVISOR_RESET;
        end else if (wr_fire) begin
            if (awaddr_q[3:2] == IDX_CTRL && wstrb_q[0]) begin
                rx_enable_q <= wdata_q[CTRL_RX_ENABLE];
                double_speed_select_q <= wdata_q[CTRL_DOUBLE_SPEED];
                address_filter_enable_q <= wdata_q[CTRL_ADDR_FILTER];
                parity_enable_q <= wdata_q[CTRL_PARITY_ENABLE];
                size_code_q <= wdata_q[CTRL_SIZE_LO +: 3];
            end
            if (awaddr_q[3:2] == IDX_BAUD) begin
                if (wstrb_q[0]) begin
                    baud_divisor_q[7:0] <= wdata_q[7:0];
                end
                if (wstrb_q[1]) begin
                    baud_divisor_q[DIV_W-1:8] <= wdata_q[DIV_W-1:8];
                end
            end
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    assign rd_take = S_AXI_ARREADY && S_AXI_ARVALID;
    assign pop = rd_take && (S_AXI_ARADDR[3:2] == IDX_DATA);

    always_ff @(posedge SYS_CLK) begin
        if (!RSTN) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= RESP_OKAY;
        end else if (rd_take) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b1;
            S_AXI_RRESP <= RESP_OKAY;
            S_AXI_RDATA <= '0;
            case (S_AXI_ARADDR[3:2])
                IDX_CTRL: begin
                    S_AXI_RDATA[CTRL_RX_ENABLE] <= rx_enable_q;
                    S_AXI_RDATA[CTRL_DOUBLE_SPEED] <= double_speed_select_q;
                    S_AXI_RDATA[CTRL_ADDR_FILTER] <= address_filter_enable_q;
                    S_AXI_RDATA[CTRL_PARITY_ENABLE] <= parity_enable_q;
                    S_AXI_RDATA[CTRL_SIZE_LO +: 3] <= size_code_q;
                end
                IDX_STATUS: begin
                    S_AXI_RDATA[STAT_RX_COMPLETE] <= rx_complete_q;
                    S_AXI_RDATA[STAT_FRAMING_ERROR] <= framing_error_flag_q;
                    S_AXI_RDATA[STAT_NINTH_BIT] <= ninth_received_bit_q;
                    S_AXI_RDATA[STAT_BUSY] <= (state_q != RX_IDLE);
                end
                IDX_DATA: begin
                    S_AXI_RDATA[7:0] <= rx_data_q;
                    S_AXI_RDATA[DATA_NINTH_POS] <= ninth_received_bit_q;
                end
                default: begin
                    S_AXI_RDATA[DIV_W-1:0] <= baud_divisor_q;
                end
            endcase
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_ARREADY <= 1'b1;
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sequence s_start_edge;
        state_q == RX_IDLE && rx_enable_q && falling;
    endsequence

    sequence s_start_good;
        state_q == RX_START && tk.tick && vote_last && !maj;
    endsequence

    a_start_detect: assert property (s_start_edge |=> state_q == RX_START && cnt_q == 5'h01)
        else $error("start not opened at sample one");
    a_start_noise: assert property (
        state_q == RX_START && tk.tick && vote_last && maj |=> state_q == RX_IDLE)
        else $error("noisy start not rejected");
    a_start_valid: assert property (
        s_start_good |=> state_q == RX_START && cnt_q == vf + 5'h02)
        else $error("valid start dropped");
    a_count_range: assert property (
        state_q != RX_IDLE |-> cnt_q >= 5'h01 && cnt_q <= spb)
        else $error("sample count outside bit");
    a_vote_bit: assert property (
        state_q == RX_DATA && tk.tick && vote_last |=> frame_q[$past(bit_idx_q)] == $past(maj))
        else $error("bit not majority of centre samples");
    a_frame_error: assert property (
        commit && !drop && rx_enable_q |=> framing_error_flag_q == !$past(maj) && rx_complete_q)
        else $error("framing error not taken from stop vote");
    a_filter_drop: assert property (
        commit && drop && !pop && rx_enable_q |=> $stable(rx_complete_q) && $stable(rx_data_q))
        else $error("filtered frame reached holding register");
    a_drop_keeps_flag: assert property (
        commit && drop |=> $stable(framing_error_flag_q))
        else $error("filtered frame touched framing error");
    a_stop_release: assert property (
        commit && !double_speed_select_q |=> state_q == RX_IDLE)
        else $error("normal mode did not rearm after stop vote");
    a_ds_release: assert property (
        commit && double_speed_select_q |=> state_q == RX_STOP && cnt_q == vf + 5'h02)
        else $error("double mode rearmed too early");
endmodule : uart_rx_recovery_addr_filter

/* File: verif/serial_tx_model.sv */
// serial transmitter model for the far end of the receive line
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps
module serial_tx_model (
    input wire logic SYS_CLK,
    output logic line_q
);
    // ----------------------------------------
    // line driver
    // ----------------------------------------
    initial line_q = 1'b1;
    task automatic hold(input logic lvl, input int clks);
        line_q <= lvl;
        repeat (clks) @(posedge SYS_CLK);
    endtask : hold
    // exact bit rate, lsb first; type bit sits in stop or ninth bit
    task automatic send(input logic [8:0] val, input int n, input logic stp, input int bclk,
                        input int sclk, input int idle);
        hold(1'b0, bclk);
        for (int i = 0; i < n; i++) begin
            hold(val[i], bclk);
        end
        hold(stp, sclk);
        // idle zero only when stop is high, so no second assignment at one edge
        if (idle > 0) begin
            hold(1'b1, idle);
        end
    endtask : send
endmodule : serial_tx_model

/* File: verif/test_uart_rx_recovery_addr_filter.sv */
// self-checking bench for the serial receive front end
// assumes design files and the transmitter model are compiled first
`timescale 1ns/1ps
module test_uart_rx_recovery_addr_filter;
    import uart_rx_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int BC = 32; // divisor 1: two clocks a sample
    localparam logic [3:0] A_CTRL = {IDX_CTRL, 2'h0};
    localparam logic [3:0] A_STAT = {IDX_STATUS, 2'h0};
    localparam logic [3:0] A_DATA = {IDX_DATA, 2'h0};
    logic sys_clk, rstn, awvalid, wvalid, bready, arvalid, rready, line;
    logic awready, wready, bvalid, arready, rvalid;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0] bresp, rresp;
    int err_total, n_tests;
    uart_rx_recovery_addr_filter i_uart_rx_recovery_addr_filter (.SYS_CLK(sys_clk),
        .RSTN(rstn), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .SERIAL_RECEIVE_INPUT(line));
    serial_tx_model i_serial_tx_model (.SYS_CLK(sys_clk), .line_q(line));
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge sys_clk);
            ad = ad | awready;
            wd = wd | wready;
            if (ad) awvalid <= 1'b0;
            if (wd) wvalid <= 1'b0;
        end
        do @(posedge sys_clk); while (bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (rvalid !== 1'b1);
        d = rdata;
        chk("rresp", 32'h0, {30'h0, rresp});
        rready <= 1'b0;
    endtask : rd
    task automatic tx(input logic [8:0] b, input int n, input logic s, input int bc);
        i_serial_tx_model.send(b, n, s, bc, bc, bc);
    endtask : tx
    task automatic frame(input logic [31:0] dat, input logic fe);
        int k;
        k = 0;
        v = 32'h0;
        while (v[STAT_RX_COMPLETE] !== 1'b1 && k < 600) begin
            rd(A_STAT, v);
            k++;
        end
        chk("complete", 32'h1, {31'h0, v[STAT_RX_COMPLETE]});
        chk("framing", {31'h0, fe}, {31'h0, v[STAT_FRAMING_ERROR]});
        chk("ninth", {31'h0, dat[8]}, {31'h0, v[STAT_NINTH_BIT]});
        rd(A_DATA, v);
        chk("data", dat, v);
        rd(A_STAT, v);
        chk("cleared", 32'h0, {31'h0, v[STAT_RX_COMPLETE]});
    endtask : frame
    task automatic drop(input logic [8:0] b, input int n, input logic s);
        tx(b, n, s, BC);
        rd(A_STAT, v);
        chk("dropped", 32'h0, v & 32'h3);
    endtask : drop
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs;
        rd({IDX_BAUD, 2'h0}, v);
        chk("baud reset", {20'h0, BAUD_DIVISOR_RESET}, v);
        rd(A_CTRL, v);
        chk("ctrl reset", {25'h0, SIZE_CODE_RESET, 4'h0}, v);
        wr(A_STAT, 32'hF, RESP_SLVERR);
        wr({IDX_BAUD, 2'h0}, 32'h1, RESP_OKAY);
        $display("done regs");
    endtask : t_regs
    // parity bit must not leak into data; short frame masks stale upper bits
    task automatic t_sizes;
        wr(A_CTRL, 32'h39, RESP_OKAY);
        tx(9'h15A, 9, 1'b1, BC);
        frame(32'h5A, 1'b0);
        wr(A_CTRL, 32'h01, RESP_OKAY);
        tx(9'h015, 5, 1'b1, BC);
        frame(32'h15, 1'b0);
        $display("done sizes");
    endtask : t_sizes
    task automatic t_normal;
        wr(A_CTRL, 32'h31, RESP_OKAY);
        tx(9'h0A5, 8, 1'b1, BC);
        frame(32'hA5, 1'b0);
        tx(9'h03C, 8, 1'b0, BC);
        frame(32'h3C, 1'b1);
        $display("done normal");
    endtask : t_normal
    // low too short to win the start vote, then a real frame
    task automatic t_noise(input int low, input int bc);
        i_serial_tx_model.hold(1'b0, low);
        i_serial_tx_model.hold(1'b1, bc);
        rd(A_STAT, v);
        chk("noise", 32'h0, v & 32'h9);
        tx(9'h0C3, 8, 1'b1, bc);
        frame(32'hC3, 1'b0);
        $display("done noise");
    endtask : t_noise
    task automatic t_back;
        wr(A_CTRL, 32'h31, RESP_OKAY);
        fork
            begin
                i_serial_tx_model.send(9'h011, 8, 1'b1, BC, 22, 0);
                tx(9'h0EE, 8, 1'b1, BC);
            end
            frame(32'h11, 1'b0);
        join
        frame(32'hEE, 1'b0);
        $display("done back to back");
    endtask : t_back
    task automatic t_filter;
        wr(A_CTRL, 32'h35, RESP_OKAY);
        tx(9'h0A3, 8, 1'b1, BC);
        frame(32'hA3, 1'b0);
        drop(9'h077, 8, 1'b0);
        wr(A_CTRL, 32'h45, RESP_OKAY);
        drop(9'h0C4, 9, 1'b1);
        tx(9'h1C4, 9, 1'b1, BC);
        frame(32'h1C4, 1'b0);
        wr(A_CTRL, 32'h41, RESP_OKAY);
        tx(9'h0C4, 9, 1'b1, BC);
        frame(32'h0C4, 1'b0);
        $display("done filter");
    endtask : t_filter
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : summarize
    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        rstn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        awaddr = 4'h0;
        araddr = 4'h0;
        wdata = 32'h0;
        err_total = 0;
        n_tests = 0;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        t_regs;
        t_sizes;
        t_normal;
        t_noise(12, BC);
        wr(A_CTRL, 32'h33, RESP_OKAY);
        t_noise(6, BC / 2);
        t_back;
        t_filter;
        summarize;
    end
    // frames run a few hundred clocks each; far beyond that means a hang
    initial begin
        repeat (40000) @(posedge sys_clk);
        err_total++;
        summarize;
    end
endmodule : test_uart_rx_recovery_addr_filter
